// [osc_ctl_pkg.sv]
// Purpose: shared constants and types of the external oscillator controller
// Assumes: 32-bit register port, byte addresses, one aligned word per register
// Notes: all offsets, field positions, reset values and cycle counts live here
package osc_ctl_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int STARTUP_UNIT_NS = 31000;
	localparam int STARTUP_UNIT_CYC = (STARTUP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MONITOR_SAFE_PERIODS = 4;
	localparam int SYNC_STAGES = 3;

	// ------------------------------------------------------------
	// register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_IRQ_ENABLE_CLEAR = 8'h00;
	localparam logic [7:0] OFS_IRQ_ENABLE_SET = 8'h04;
	localparam logic [7:0] OFS_IRQ_FLAG = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_EXT_OSC_CTRL = 8'h10;
	localparam logic [7:0] OFS_EVENT_CTRL = 8'h14;
	localparam logic [7:0] OFS_SAFE_PRESCALE = 8'h18;

	// irq flag / enable / status bit positions
	localparam int BIT_READY = 0;
	localparam int BIT_CLOCK_FAIL = 1;
	localparam int BIT_SAFE_ACTIVE = 2;

	// external oscillator control fields and event control field
	localparam int POS_ENABLE = 1;
	localparam int POS_CRYSTAL_SELECT = 2;
	localparam int POS_FAIL_DETECT_EN = 3;
	localparam int POS_RETURN_TO_EXT = 4;
	localparam int POS_RUN_IN_STANDBY = 6;
	localparam int POS_ON_REQUEST_ONLY = 7;
	localparam int POS_GAIN = 8;
	localparam int POS_AUTO_AMPLITUDE = 11;
	localparam int POS_STARTUP = 12;
	localparam int POS_EVENT_OUT_EN = 0;

	localparam int GAIN_W = 3;
	localparam int STARTUP_W = 4;
	localparam int PRESCALE_W = 4;

	// reset values
	localparam logic [GAIN_W-1:0] RST_GAIN = 3'h0;
	localparam logic [STARTUP_W-1:0] RST_STARTUP = 4'h0;
	localparam logic [PRESCALE_W-1:0] RST_PRESCALE = 4'h0;
	localparam logic [1:0] RST_IRQ = 2'h0;

	// ------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic wr;
		logic rd;
	} reg_req_t;

	typedef struct packed {
		logic [STARTUP_W-1:0] startup;
		logic auto_amplitude_ctl;
		logic [GAIN_W-1:0] gain;
		logic on_request_only;
		logic run_in_standby;
		logic return_to_ext_clock;
		logic fail_detect_en;
		logic crystal_select;
		logic enable;
	} osc_ctrl_t;

	typedef struct packed {
		logic osc_run;
		logic crystal_mode;
		logic [GAIN_W-1:0] gain;
		logic auto_amplitude;
		logic osc_in_pin_override;
		logic osc_out_pin_override;
	} analog_ctl_t;

	typedef struct packed {
		osc_ctrl_t ctrl;
		logic [1:0] ien;
		logic [1:0] flag;
		logic [PRESCALE_W-1:0] presc;
		logic evt_en;
		logic run_q;
		logic ready;
		logic safe_active;
		logic fail_q;
		logic [23:0] st_cnt;
		logic [31:0] rdata;
		logic clk_out;
		logic evt;
		analog_ctl_t ana;
	} top_state_t;

endpackage

// [pin_sync.sv]
// Purpose: three-stage synchroniser with agreement filter for pin inputs
// Assumes: inputs come from outside the clk_i domain
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic [WIDTH-1:0] async_i,
	output logic [WIDTH-1:0] sync_o
);
	import osc_ctl_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] out;
	} sync_state_t;

	sync_state_t st;
	sync_state_t next_st;

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.s1 = async_i;
		next_st.s2 = st.s1;
		next_st.s3 = st.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st.s2[i] == st.s3[i]) begin
				next_st.out[i] = st.s3[i];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign sync_o = st.out;
endmodule // pin_sync

// [clock_fail_detector.sv]
// Purpose: safe clock prescaler and activity monitor for the external clock
// Assumes: both clock levels already synchronised to clk_i
// Notes: safe clock period is 2^P fast-oscillator periods
`timescale 1ns/1ps
module clock_fail_detector (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire logic enable_i,
	input wire logic ext_lvl_i,
	input wire logic fast_lvl_i,
	input wire logic [osc_ctl_pkg::PRESCALE_W-1:0] presc_i,
	output logic safe_lvl_o,
	output logic fail_o
);
	import osc_ctl_pkg::*;

	typedef struct packed {
		logic fast_q;
		logic ext_q;
		logic [15:0] half_cnt;
		logic safe_lvl;
		logic [2:0] win_cnt;
		logic seen_rise;
		logic seen_fall;
		logic fail;
	} cfd_state_t;

	cfd_state_t st;
	cfd_state_t next_st;
	logic [15:0] half_lim;
	logic safe_rise;

	// ------------------------------------------------------------
	// prescaler and monitor window
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		half_lim = (16'h0001 << presc_i) - 16'h0001;
		safe_rise = 1'b0;
		next_st.fast_q = fast_lvl_i;
		next_st.ext_q = ext_lvl_i;
		// count fast half periods, toggle every 2^P of them
		if (fast_lvl_i != st.fast_q) begin
			if (st.half_cnt >= half_lim) begin
				next_st.half_cnt = 16'h0000;
				next_st.safe_lvl = ~st.safe_lvl;
				safe_rise = ~st.safe_lvl;
			end else begin
				next_st.half_cnt = st.half_cnt + 16'h0001;
			end
		end
		if (!enable_i) begin
			// monitoring off: no verdict kept, window restarts cleanly
			next_st.win_cnt = 3'h0;
			next_st.seen_rise = 1'b0;
			next_st.seen_fall = 1'b0;
			next_st.fail = 1'b0;
		end else begin
			if (ext_lvl_i && !st.ext_q) begin
				next_st.seen_rise = 1'b1;
			end
			if (!ext_lvl_i && st.ext_q) begin
				next_st.seen_fall = 1'b1;
			end
			if (safe_rise) begin
				if (st.win_cnt == 3'(MONITOR_SAFE_PERIODS - 1)) begin
					// status tracks the latest window's activity
					next_st.fail = !(st.seen_rise && st.seen_fall);
					next_st.win_cnt = 3'h0;
					next_st.seen_rise = 1'b0;
					next_st.seen_fall = 1'b0;
				end else begin
					next_st.win_cnt = st.win_cnt + 3'h1;
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign safe_lvl_o = st.safe_lvl;
	assign fail_o = st.fail;
endmodule // clock_fail_detector

// [ext_osc_controller.sv]
// Purpose: external oscillator control with start-up masking and clock fail detection
// Assumes: oscillator and fast oscillator arrive as pins, sampled on clk_i (10 MHz)
// Notes: output clock is a sampled image, usable only for clocks well below clk_i
//
// The register offsets and the plain strobed port were decided locally.
`timescale 1ns/1ps

module ext_osc_controller #(
	parameter int STARTUP_UNIT = osc_ctl_pkg::STARTUP_UNIT_CYC
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire osc_ctl_pkg::reg_req_t bus_i,
	output logic [31:0] rdata_o,
	input wire logic ext_osc_clk_i,
	input wire logic fast_osc_clk_i,
	input wire logic standby_i,
	input wire logic periph_req_i,
	input wire logic write_guard_i,
	input wire logic debug_halt_i,
	input wire logic debugger_access_i,
	output osc_ctl_pkg::analog_ctl_t analog_o,
	output logic clk_out_o,
	output logic clk_valid_o,
	output logic clock_fail_evt_o,
	output logic irq_o
);
	import osc_ctl_pkg::*;

	// ------------------------------------------------------------
	// elaboration checks
	// ------------------------------------------------------------
	// the start-up counter must hold the longest delay (unit << 15)
	if (STARTUP_UNIT < 1 || STARTUP_UNIT > 511) begin : g_bad_unit
		$error("STARTUP_UNIT out of range 1..511");
	end

	// the fail window counter is three bits, so at most eight safe periods
	if (MONITOR_SAFE_PERIODS < 1 || MONITOR_SAFE_PERIODS > 8) begin : g_bad_window
		$error("MONITOR_SAFE_PERIODS out of range 1..8");
	end

	// the pin synchroniser is built with exactly three stages
	if (SYNC_STAGES != 3) begin : g_bad_sync
		$error("SYNC_STAGES must be 3");
	end

	top_state_t st;
	top_state_t next_st;

	logic [1:0] pin_lvl;
	logic ext_lvl;
	logic fast_lvl;
	logic safe_lvl;
	logic fail_now;

	logic run_now;
	logic monitor_en;

	logic guarded;
	logic wr_ok;

	logic [1:0] flag_set;
	logic [23:0] startup_cycles;

	logic [31:0] ctrl_word;
	logic [31:0] status_word;

	// ------------------------------------------------------------
	// oscillator-side inputs
	// ------------------------------------------------------------
	// both oscillator signals are foreign to clk_i
	pin_sync #(
		.WIDTH(2)
	) u_sync (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.async_i({fast_osc_clk_i, ext_osc_clk_i}),
		.sync_o(pin_lvl)
	);

	assign ext_lvl = pin_lvl[0];
	assign fast_lvl = pin_lvl[1];

	// the monitor sees only synchronised levels, never the raw pins
	clock_fail_detector u_cfd (
		.clk_i(clk_i),
		.sys_rst_i(sys_rst_i),
		.ce_i(ce_i),
		.enable_i(monitor_en),
		.ext_lvl_i(ext_lvl),
		.fast_lvl_i(fast_lvl),
		.presc_i(st.presc),
		.safe_lvl_o(safe_lvl),
		.fail_o(fail_now)
	);

	// ------------------------------------------------------------
	// run decision and monitor gating
	// ------------------------------------------------------------
	always_comb begin
		if (!st.ctrl.enable) begin
			run_now = 1'b0;
		end else if (!standby_i) begin
			if (st.ctrl.on_request_only) begin
				run_now = periph_req_i;
			end else begin
				run_now = 1'b1;
			end
		end else if (st.ctrl.run_in_standby && !st.ctrl.on_request_only) begin
			run_now = 1'b1;
		end else begin
			run_now = periph_req_i;
		end
	end

	// monitoring waits for ready so start-up noise is never a failure
	assign monitor_en = st.ctrl.fail_detect_en && st.ready && run_now
		&& !(standby_i && !periph_req_i);

	// debugger and debug halt always pass the guard
	assign guarded = write_guard_i && !debug_halt_i && !debugger_access_i;
	assign wr_ok = bus_i.wr && !guarded;

	// longest delay is the unit shifted by 15, which 24 bits still hold
	assign startup_cycles = 24'(STARTUP_UNIT) << st.ctrl.startup;

	// ------------------------------------------------------------
	// read images
	// ------------------------------------------------------------
	always_comb begin
		ctrl_word = 32'h0000_0000;
		ctrl_word[POS_ENABLE] = st.ctrl.enable;
		ctrl_word[POS_CRYSTAL_SELECT] = st.ctrl.crystal_select;
		ctrl_word[POS_FAIL_DETECT_EN] = st.ctrl.fail_detect_en;
		ctrl_word[POS_RETURN_TO_EXT] = st.ctrl.return_to_ext_clock;
		ctrl_word[POS_RUN_IN_STANDBY] = st.ctrl.run_in_standby;
		ctrl_word[POS_ON_REQUEST_ONLY] = st.ctrl.on_request_only;
		ctrl_word[POS_GAIN +: GAIN_W] = st.ctrl.gain;
		ctrl_word[POS_AUTO_AMPLITUDE] = st.ctrl.auto_amplitude_ctl;
		ctrl_word[POS_STARTUP +: STARTUP_W] = st.ctrl.startup;

		status_word = 32'h0000_0000;
		status_word[BIT_READY] = st.ready;
		status_word[BIT_CLOCK_FAIL] = st.fail_q;
		status_word[BIT_SAFE_ACTIVE] = st.safe_active;
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		flag_set = 2'b00;
		// the fail event is a single-cycle pulse
		next_st.evt = 1'b0;
		// run_q keeps last cycle's decision so a fresh start is seen
		next_st.run_q = run_now;

		// start-up delay: restarts whenever the oscillator turns on
		if (!run_now) begin
			next_st.ready = 1'b0;
			next_st.st_cnt = 24'h00_0000;
		end else if (!st.run_q) begin
			next_st.ready = 1'b0;
			next_st.st_cnt = startup_cycles;
		end else if (st.st_cnt != 24'h00_0000) begin
			next_st.st_cnt = st.st_cnt - 24'h00_0001;
		end else begin
			next_st.ready = 1'b1;
		end

		if (next_st.ready && !st.ready) begin
			flag_set[BIT_READY] = 1'b1;
		end

		// failure status and safe clock switch
		next_st.fail_q = fail_now;
		if (fail_now && !st.fail_q) begin
			flag_set[BIT_CLOCK_FAIL] = 1'b1;
			// once already on the safe clock no further event is sent
			next_st.evt = st.evt_en && !st.safe_active;
			next_st.safe_active = 1'b1;
		end

		// software register writes
		if (wr_ok) begin
			unique case (bus_i.addr)
				OFS_EXT_OSC_CTRL: begin
					next_st.ctrl.enable = bus_i.wdata[POS_ENABLE];
					next_st.ctrl.crystal_select = bus_i.wdata[POS_CRYSTAL_SELECT];
					next_st.ctrl.fail_detect_en = bus_i.wdata[POS_FAIL_DETECT_EN];
					// software can only set the return bit; hardware clears it
					next_st.ctrl.return_to_ext_clock = bus_i.wdata[POS_RETURN_TO_EXT]
						| st.ctrl.return_to_ext_clock;
					next_st.ctrl.run_in_standby = bus_i.wdata[POS_RUN_IN_STANDBY];
					next_st.ctrl.on_request_only = bus_i.wdata[POS_ON_REQUEST_ONLY];
					next_st.ctrl.gain = bus_i.wdata[POS_GAIN +: GAIN_W];
					next_st.ctrl.auto_amplitude_ctl = bus_i.wdata[POS_AUTO_AMPLITUDE];
					next_st.ctrl.startup = bus_i.wdata[POS_STARTUP +: STARTUP_W];
				end
				// set and clear registers touch only the bits written as one
				OFS_IRQ_ENABLE_SET: begin
					next_st.ien = st.ien | bus_i.wdata[1:0];
				end
				OFS_IRQ_ENABLE_CLEAR: begin
					next_st.ien = st.ien & ~bus_i.wdata[1:0];
				end
				OFS_EVENT_CTRL: begin
					next_st.evt_en = bus_i.wdata[POS_EVENT_OUT_EN];
				end
				OFS_SAFE_PRESCALE: begin
					next_st.presc = bus_i.wdata[PRESCALE_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// flag register is never guarded; a new event beats the clear
		if (bus_i.wr && bus_i.addr == OFS_IRQ_FLAG) begin
			next_st.flag = (st.flag & ~bus_i.wdata[1:0]) | flag_set;
		end else begin
			next_st.flag = st.flag | flag_set;
		end

		// switch back once the external clock shows activity again
		if (st.ctrl.return_to_ext_clock) begin
			if (!st.safe_active) begin
				next_st.ctrl.return_to_ext_clock = 1'b0;
			// a window that still fails keeps the safe clock
			end else if (!fail_now) begin
				next_st.safe_active = 1'b0;
				next_st.ctrl.return_to_ext_clock = 1'b0;
			end
		end

		// output clock: masked until ready, safe clock after a failure
		// both edges of ready are masked so no stray half cycle escapes
		if (!st.ready || !next_st.ready) begin
			next_st.clk_out = 1'b0;
		end else if (st.safe_active) begin
			next_st.clk_out = safe_lvl;
		end else begin
			next_st.clk_out = ext_lvl;
		end

		// analog core and pin takeover
		next_st.ana.osc_run = run_now;
		next_st.ana.crystal_mode = st.ctrl.crystal_select;
		next_st.ana.gain = st.ctrl.gain;
		next_st.ana.auto_amplitude = st.ctrl.auto_amplitude_ctl;
		// overrides are levels for the pad mux; the pad itself lives outside
		next_st.ana.osc_in_pin_override = st.ctrl.enable;
		next_st.ana.osc_out_pin_override = st.ctrl.enable && st.ctrl.crystal_select;

		// read port: data valid in the cycle after the strobe only
		next_st.rdata = 32'h0000_0000;
		if (bus_i.rd) begin
			unique case (bus_i.addr)
				OFS_IRQ_ENABLE_CLEAR: begin
					next_st.rdata = {30'h0000_0000, st.ien};
				end
				OFS_IRQ_ENABLE_SET: begin
					next_st.rdata = {30'h0000_0000, st.ien};
				end
				OFS_IRQ_FLAG: begin
					next_st.rdata = {30'h0000_0000, st.flag};
				end
				OFS_STATUS: begin
					next_st.rdata = status_word;
				end
				OFS_EXT_OSC_CTRL: begin
					next_st.rdata = ctrl_word;
				end
				OFS_EVENT_CTRL: begin
					next_st.rdata = {31'h0000_0000, st.evt_en};
				end
				OFS_SAFE_PRESCALE: begin
					next_st.rdata = {28'h000_0000, st.presc};
				end
				default: begin
					next_st.rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			st <= '0;
			st.ctrl.gain <= RST_GAIN;
			st.ctrl.startup <= RST_STARTUP;
			st.presc <= RST_PRESCALE;
			st.ien <= RST_IRQ;
			st.flag <= RST_IRQ;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign rdata_o = st.rdata;
	assign analog_o = st.ana;
	assign clk_out_o = st.clk_out;
	assign clk_valid_o = st.ready;
	assign clock_fail_evt_o = st.evt;
	// combinational so a flag clear drops the request at once
	assign irq_o = |(st.flag & st.ien);
endmodule // ext_osc_controller

// [ext_osc_model.sv]
// Purpose: behavioural external crystal or clock source and internal fast oscillator
// Assumes: both periods are slow against the 100 ns sampling clock
// Notes: a halted source freezes its pin, which is how a broken crystal looks
`timescale 1ns/1ps
module ext_osc_model #(
	parameter int EXT_HALF_NS = 700,
	parameter int FAST_HALF_NS = 300,
	parameter logic [2:0] MATCH_GAIN = 3'h2
) (
	input wire osc_ctl_pkg::analog_ctl_t analog_i,
	input wire logic halt_i,
	output logic ext_clk_o,
	output logic fast_clk_o
);
	import osc_ctl_pkg::*;
	// ------------------------------------------------------------
	// sources
	// ------------------------------------------------------------
	logic swing;
	// a crystal only swings with the drive gain that suits it, so a wrong gain shows as a failure
	assign swing = analog_i.osc_run && analog_i.osc_in_pin_override && !halt_i
		&& (!analog_i.crystal_mode || analog_i.gain == MATCH_GAIN);
	initial begin
		ext_clk_o = 1'b0;
		fast_clk_o = 1'b0;
	end
	always #FAST_HALF_NS fast_clk_o = ~fast_clk_o;
	always begin
		#EXT_HALF_NS;
		if (swing) begin
			ext_clk_o = ~ext_clk_o;
		end else if (!analog_i.osc_run) begin
			ext_clk_o = 1'b0;
		end
	end
endmodule // ext_osc_model

// [osc_ctl_props.sv]
// Purpose: port-level checks of the external oscillator controller
// Assumes: ce_i stays high around control writes
// Notes: bound into every controller instance
`timescale 1ns/1ps
module osc_ctl_props #(
	parameter int STARTUP_UNIT = 1
) (
	input wire logic clk_i,
	input wire logic sys_rst_i,
	input wire logic ce_i,
	input wire osc_ctl_pkg::reg_req_t bus_i,
	input wire logic [31:0] rdata_o,
	input wire logic standby_i,
	input wire logic periph_req_i,
	input wire logic write_guard_i,
	input wire logic debug_halt_i,
	input wire logic debugger_access_i,
	input wire osc_ctl_pkg::analog_ctl_t analog_o,
	input wire logic clk_out_o,
	input wire logic clk_valid_o,
	input wire logic clock_fail_evt_o
);
	import osc_ctl_pkg::*;
	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	logic [9:0] run_cnt;
	logic open_wr;
	assign open_wr = !write_guard_i || debug_halt_i || debugger_access_i;
	// saturates so a long run never wraps into a false short start-up
	always_ff @(posedge clk_i) begin
		if (sys_rst_i || !analog_o.osc_run) begin
			run_cnt <= 10'h000;
		end else if (run_cnt != 10'h3ff) begin
			run_cnt <= run_cnt + 10'h001;
		end
	end
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);
	sequence ctrl_wr_s;
		ce_i && bus_i.wr && bus_i.addr == OFS_EXT_OSC_CTRL && open_wr;
	endsequence
	sequence run_req_s;
		ctrl_wr_s ##0 (bus_i.wdata[POS_ENABLE] && !bus_i.wdata[POS_ON_REQUEST_ONLY] && !standby_i) ##1 !standby_i;
	endsequence
	sequence sleep_idle_s;
		(standby_i && !periph_req_i) [*4];
	endsequence
	rdata_idle_a: assert property ($past(ce_i) && !$past(bus_i.rd) |-> rdata_o == 32'h0000_0000)
		else $error("read data outside answer cycle");
	mask_output_a: assert property (!clk_valid_o |-> !clk_out_o)
		else $error("clock out while not ready");
	out_pin_a: assert property (analog_o.osc_out_pin_override |-> analog_o.crystal_mode && analog_o.osc_in_pin_override)
		else $error("output pin taken outside crystal mode");
	evt_pulse_a: assert property (clock_fail_evt_o |=> !clock_fail_evt_o)
		else $error("fail event longer than one cycle");
	ready_drop_a: assert property (!analog_o.osc_run && !$past(analog_o.osc_run) |-> !clk_valid_o)
		else $error("ready while oscillator stopped");
	startup_len_a: assert property ($rose(clk_valid_o) |-> int'(run_cnt) >= STARTUP_UNIT)
		else $error("ready before start-up delay");
	no_early_fail_a: assert property (clock_fail_evt_o |-> $past(clk_valid_o))
		else $error("failure during start-up");
	gain_follow_a: assert property (ctrl_wr_s |=> ##1 analog_o.gain == $past(bus_i.wdata[POS_GAIN +: GAIN_W], 2))
		else $error("gain not passed on");
	ctrl_off_a: assert property (ctrl_wr_s ##0 !bus_i.wdata[POS_ENABLE] |=> ##1 !analog_o.osc_run)
		else $error("oscillator runs while disabled");
	ctrl_on_a: assert property (run_req_s |=> analog_o.osc_run)
		else $error("oscillator not started");
	sleep_quiet_a: assert property (sleep_idle_s |-> !clock_fail_evt_o)
		else $error("failure reported in idle sleep");
endmodule // osc_ctl_props

bind ext_osc_controller osc_ctl_props #(.STARTUP_UNIT(STARTUP_UNIT)) props (.clk_i, .sys_rst_i, .ce_i, .bus_i,
	.rdata_o, .standby_i, .periph_req_i, .write_guard_i, .debug_halt_i, .debugger_access_i, .analog_o,
	.clk_out_o, .clk_valid_o, .clock_fail_evt_o);

// [ext_osc_control_with_fail_detect_tb.sv]
// Purpose: self-checking bench for the external oscillator controller
// Assumes: start-up unit shortened to four cycles, prescale one
// Notes: register and run-mode cases run from tables; failure and guard cases by hand
`timescale 1ns/1ps
module ext_osc_control_with_fail_detect_tb;
	import osc_ctl_pkg::*;
	// ------------------------------------------------------------
	// stimulus
	// ------------------------------------------------------------
	localparam int SU = 4;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} row_t;
	logic clk_i = 1'b0;
	logic sys_rst_i = 1'b1;
	logic ce_i = 1'b1;
	reg_req_t bus_i = '0;
	logic standby_i = 1'b0;
	logic periph_req_i = 1'b0;
	logic write_guard_i = 1'b0;
	logic debug_halt_i = 1'b0;
	logic debugger_access_i = 1'b0;
	logic halt = 1'b0;
	logic ext_osc_clk_i;
	logic fast_osc_clk_i;
	logic [31:0] rdata_o;
	analog_ctl_t analog_o;
	logic clk_out_o;
	logic clk_valid_o;
	logic clock_fail_evt_o;
	logic irq_o;
	logic saw_out;
	logic [31:0] d;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int n;
	row_t rows [8] = '{'{8'h10, 32'h0, 32'h0}, '{8'h18, 32'hffff_fff3, 32'h3}, '{8'h14, 32'hffff_ffff, 32'h1},
		'{8'h04, 32'h3, 32'h3}, '{8'h00, 32'h1, 32'h2}, '{8'h20, 32'hffff_ffff, 32'h0},
		'{8'h0c, 32'hffff_ffff, 32'h0}, '{8'h10, 32'hfed0, 32'hfec0}};
	// enable, standby, run_in_standby, on_request_only, request, expected run
	logic [5:0] modes [8] = '{6'h0a, 6'h21, 6'h24, 6'h27, 6'h39, 6'h3c, 6'h30, 6'h33};
	always #50 clk_i = ~clk_i;
	ext_osc_controller #(.STARTUP_UNIT(SU)) uut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .bus_i(bus_i),
		.rdata_o(rdata_o), .ext_osc_clk_i(ext_osc_clk_i), .fast_osc_clk_i(fast_osc_clk_i), .standby_i(standby_i),
		.periph_req_i(periph_req_i), .write_guard_i(write_guard_i), .debug_halt_i(debug_halt_i),
		.debugger_access_i(debugger_access_i), .analog_o(analog_o), .clk_out_o(clk_out_o),
		.clk_valid_o(clk_valid_o), .clock_fail_evt_o(clock_fail_evt_o), .irq_o(irq_o));
	ext_osc_model model (.analog_i(analog_o), .halt_i(halt), .ext_clk_o(ext_osc_clk_i), .fast_clk_o(fast_osc_clk_i));
	task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
		@(posedge clk_i);
		bus_i.wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_i);
		bus_i <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
		@(posedge clk_i);
		bus_i.rd <= 1'b0;
		#10;
		v = rdata_o;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input string name);
		rd(a, d);
		chk(name, e, d);
	endtask
	task automatic wait_ready(input int lo);
		n = 0;
		saw_out = 1'b0;
		while (clk_valid_o !== 1'b1 && n < 400) begin
			@(posedge clk_i);
			#1;
			n++;
			saw_out = saw_out | clk_out_o;
		end
		chk("start-up length", 32'h1, {31'h0, n >= lo && n <= lo + 6});
		chk("masked output", 32'h0, {31'h0, saw_out});
		d = 32'h0;
		repeat (40) begin
			@(posedge clk_i);
			#1;
			d = d + {31'h0, clk_out_o};
		end
		chk("clock passes", 32'h1, {31'h0, d > 5 && d < 35});
	endtask
	task automatic final_report();
		$display("errors=%0d checks_done=%0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// the whole run takes a few hundred cycles; a hang is cut well above that
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 20000) begin
			errors++;
			final_report();
		end
	end
	initial begin
		repeat (6) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		#1;
		chk("outputs at reset", 32'h0, {20'h0, analog_o, clk_out_o, clk_valid_o, clock_fail_evt_o, irq_o});
		for (int i = 0; i < 8; i++) begin
			rdchk(8'(i * 4), 32'h0, "reset value");
		end
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rdchk(rows[i].addr, rows[i].exp, "table read");
		end
		wr(OFS_IRQ_ENABLE_SET, 32'h3);
		wr(OFS_EXT_OSC_CTRL, 32'h000a);
		wait_ready(SU);
		chk("clock mode pins", 32'h2, {30'h0, analog_o.osc_in_pin_override, analog_o.osc_out_pin_override});
		chk("clock mode", 32'h0, {31'h0, analog_o.crystal_mode});
		rdchk(OFS_STATUS, 32'h1, "ready status");
		chk("ready irq", 32'h1, {31'h0, irq_o});
		rdchk(OFS_IRQ_FLAG, 32'h1, "ready flag");
		wr(OFS_EXT_OSC_CTRL, 32'h0);
		write_guard_i <= 1'b1;
		wr(OFS_IRQ_FLAG, 32'h1);
		rdchk(OFS_IRQ_FLAG, 32'h0, "guarded flag clear");
		chk("irq cleared", 32'h0, {31'h0, irq_o});
		wr(OFS_SAFE_PRESCALE, 32'h5);
		rdchk(OFS_SAFE_PRESCALE, 32'h3, "guarded write");
		debug_halt_i <= 1'b1;
		wr(OFS_SAFE_PRESCALE, 32'h2);
		rdchk(OFS_SAFE_PRESCALE, 32'h2, "debug halt write");
		debug_halt_i <= 1'b0;
		debugger_access_i <= 1'b1;
		wr(OFS_SAFE_PRESCALE, 32'h1);
		rdchk(OFS_SAFE_PRESCALE, 32'h1, "debugger write");
		debugger_access_i <= 1'b0;
		write_guard_i <= 1'b0;
		// drive gain matched to the attached crystal, start-up field two
		wr(OFS_EXT_OSC_CTRL, 32'h2a0e);
		wait_ready(4 * SU);
		chk("crystal pins", 32'h7, {29'h0, analog_o.crystal_mode, analog_o.osc_in_pin_override,
			analog_o.osc_out_pin_override});
		chk("auto amplitude", 32'h1, {31'h0, analog_o.auto_amplitude});
		halt <= 1'b1;
		n = 0;
		while (clock_fail_evt_o !== 1'b1 && n < 300) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		chk("fail latency", 32'h1, {31'h0, n <= 106});
		rdchk(OFS_STATUS, 32'h7, "fail status");
		rdchk(OFS_IRQ_FLAG, 32'h3, "fail flag");
		chk("fail irq", 32'h1, {31'h0, irq_o});
		d = 32'h0;
		repeat (24) begin
			@(posedge clk_i);
			#1;
			d = d + {31'h0, clk_out_o};
		end
		chk("safe clock out", 32'h1, {31'h0, d > 6 && d < 18});
		halt <= 1'b0;
		wr(OFS_EXT_OSC_CTRL, 32'h2a1e);
		n = 0;
		d = 32'h10;
		while (d[POS_RETURN_TO_EXT] !== 1'b0 && n < 60) begin
			rd(OFS_EXT_OSC_CTRL, d);
			n++;
		end
		chk("return bit", 32'h2a0e, d);
		rdchk(OFS_STATUS, 32'h1, "switched back");
		wr(OFS_IRQ_FLAG, 32'h3);
		foreach (modes[i]) begin
			@(posedge clk_i);
			standby_i <= modes[i][4];
			periph_req_i <= modes[i][1];
			wr(OFS_EXT_OSC_CTRL, {24'h0, modes[i][2], modes[i][3], 2'b00, 1'b1, 1'b0, modes[i][5], 1'b0});
			repeat (3) @(posedge clk_i);
			#1;
			chk("osc run", {31'h0, modes[i][0]}, {31'h0, analog_o.osc_run});
		end
		final_report();
	end
endmodule // ext_osc_control_with_fail_detect_tb
